// File: dbtc_cfg.svh
`ifndef DBTC_CFG_SVH
`define DBTC_CFG_SVH

// register byte offsets on the AHB-Lite slave
`define DBTC_OFF_CTRL_A 4'h0
`define DBTC_OFF_CTRL_B 4'h4
`define DBTC_OFF_STATUS 4'h8

// control word width and reset value: trim[6:4] sync[3] stretch[2] inhibit[1] rcvEnable[0]
`define DBTC_CTRL_W 7
`define DBTC_CTRL_RST 7'h05

// status field positions inside one bus slice, and the slice pitch
`define DBTC_ST_RCV 0
`define DBTC_ST_RCV_INV 1
`define DBTC_ST_DRV_POS 2
`define DBTC_ST_DRV_NEG 3
`define DBTC_ST_DRV_OE 4
`define DBTC_ST_PITCH 8

// timing
`define DBTC_CLK_PERIOD_NS 20
`define DBTC_STRETCH_NS 300
`define DBTC_STRETCH_CYC ((`DBTC_STRETCH_NS + `DBTC_CLK_PERIOD_NS - 1) / `DBTC_CLK_PERIOD_NS)
`define DBTC_STRETCH_W 5

`endif

// File: dbtc_pkg.sv
`include "dbtc_cfg.svh"

package dbtc_pkg;

   // per-bus control, laid out exactly as the control register
   typedef struct packed {
      logic [2:0] trimCode;
      logic syncEnable;
      logic stretchEn;
      logic xmitInhibit;
      logic rcvEnable;
   } dbtc_ctrl_t;

   // one stretched receive channel
   typedef struct packed {
      logic level;
      logic [`DBTC_STRETCH_W-1:0] count;
   } dbtc_stretch_t;

   // state of the top: control, receive path, bus slave
   typedef struct packed {
      dbtc_ctrl_t [1:0] ctrl;
      logic [1:0][1:0][1:0] rcvSync;
      dbtc_stretch_t [1:0][1:0] rcv;
      logic dataPhase;
      logic dataWrite;
      logic dataHit;
      logic [1:0] dataIdx;
      logic [31:0] rdata;
   } dbtc_top_state_t;

   // lane state on the sync clock
   typedef struct packed {
      logic [1:0] rstSync;
      logic [1:0] pair;
      logic toggle;
   } dbtc_link_state_t;

   // lane state on the system clock
   typedef struct packed {
      logic [1:0][1:0] padSync;
      logic [2:0] togSync;
      logic [1:0] syncPair;
      logic drvPos;
      logic drvNeg;
      logic drvOe;
      logic [2:0] trimSel;
   } dbtc_lane_state_t;

endpackage

// File: dbtc_xmit_lane.sv
module dbtc_xmit_lane import dbtc_pkg::*; (
   // system clock and reset
   input wire logic clk,
   input wire logic rst,
   // link side pins
   input wire logic syncClock,
   input wire logic xmitData,
   input wire logic xmitDataInv,
   // control
   input wire logic xmitInhibit,
   input wire logic syncEnable,
   input wire logic [2:0] trimCode,
   // driver
   output logic drvPos,
   output logic drvNeg,
   output logic drvOe,
   output logic [2:0] trimSel
);

   dbtc_link_state_t lnk_reg, lnk_next;
   dbtc_lane_state_t st_reg, st_next;
   logic [1:0] src;

   // sync clock domain: capture the pair on the rising edge, toggle once per edge
   always_comb begin
      lnk_next = lnk_reg;
      lnk_next.rstSync = {lnk_reg.rstSync[0], rst};
      lnk_next.pair = {xmitData, xmitDataInv};
      lnk_next.toggle = ~lnk_reg.toggle;
      if (lnk_reg.rstSync[1]) begin
         lnk_next.pair = 2'h0;
         lnk_next.toggle = 1'b0;
      end
   end

   always_ff @(posedge syncClock) begin
      lnk_reg <= lnk_next;
   end

   // system clock: pad synchronisers, toggle crossing, driver decision
   always_comb begin
      st_next = st_reg;
      src = st_reg.padSync[1];
      st_next.padSync[0] = {xmitData, xmitDataInv};
      st_next.padSync[1] = st_reg.padSync[0];
      st_next.togSync = {st_reg.togSync[1:0], lnk_reg.toggle};
      // pair is stable for a whole sync period after its toggle, so take it as one word
      if (st_reg.togSync[2] != st_reg.togSync[1]) begin
         st_next.syncPair = lnk_reg.pair;
      end
      // bypass ignores the sync clock entirely
      if (syncEnable) begin
         src = st_reg.syncPair;
      end else begin
         src = st_reg.padSync[1];
      end
      st_next.drvPos = src[1];
      st_next.drvNeg = src[0];
      // equal levels or inhibit leave the driver in high impedance
      st_next.drvOe = !xmitInhibit && (src[1] != src[0]);
      st_next.trimSel = trimCode;
      if (rst) begin
         st_next = '0;
      end
   end

   always_ff @(posedge clk) begin
      st_reg <= st_next;
   end

   // outputs straight from flip-flops
   assign drvPos = st_reg.drvPos;
   assign drvNeg = st_reg.drvNeg;
   assign drvOe = st_reg.drvOe;
   assign trimSel = st_reg.trimSel;

endmodule // dbtc_xmit_lane

// File: dbtc_top.sv
`include "dbtc_cfg.svh"

module dbtc_top import dbtc_pkg::*; #(
   parameter int STRETCH_CYC = `DBTC_STRETCH_CYC
) (
   // system clock and synchronous reset
   input wire logic clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // bus A transmit pins
   input wire logic syncClockA,
   input wire logic xmitDataA,
   input wire logic xmitDataInvA,
   // bus B transmit pins
   input wire logic syncClockB,
   input wire logic xmitDataB,
   input wire logic xmitDataInvB,
   // receiver comparator levels, asynchronous
   input wire logic busRcvPosA,
   input wire logic busRcvNegA,
   input wire logic busRcvPosB,
   input wire logic busRcvNegB,
   // receive output pairs
   output logic rcvDataA,
   output logic rcvDataInvA,
   output logic rcvDataB,
   output logic rcvDataInvB,
   // line drivers, three-state
   output logic lineDriverPosA,
   output logic lineDriverNegA,
   output logic lineDriverOeA,
   output logic lineDriverPosB,
   output logic lineDriverNegB,
   output logic lineDriverOeB,
   // driver trim selections
   output logic [2:0] trimSelA,
   output logic [2:0] trimSelB
);

   localparam logic [`DBTC_STRETCH_W-1:0] STRETCH_LOAD = `DBTC_STRETCH_W'(STRETCH_CYC - 1);
   localparam logic [1:0] IDX_CTRL_A = 2'(`DBTC_OFF_CTRL_A >> 2);
   localparam logic [1:0] IDX_CTRL_B = 2'(`DBTC_OFF_CTRL_B >> 2);
   localparam logic [1:0] IDX_STATUS = 2'(`DBTC_OFF_STATUS >> 2);

   // the hold counter must fit its field and hold at least one cycle
   if (STRETCH_CYC < 1 || STRETCH_CYC > (1 << `DBTC_STRETCH_W)) begin : g_bad_stretch
      $error("STRETCH_CYC out of range for the hold counter");
   end

   dbtc_top_state_t st_reg, st_next;
   logic [1:0] syncClk, xData, xDataInv, rawPos, rawNeg;
   logic [1:0] drvPos, drvNeg, drvOe;
   logic [1:0][2:0] trimSel;
   logic [31:0] statusWord;
   logic accept;

   // is the index one of the two control registers
   function automatic logic isCtrl(input logic [1:0] idx);
      return (idx == IDX_CTRL_A) || (idx == IDX_CTRL_B);
   endfunction

   // control register slot addressed by an index
   function automatic logic ctrlSlot(input logic [1:0] idx);
      return idx == IDX_CTRL_B;
   endfunction

   // read multiplexer; unmapped words read as zero
   function automatic logic [31:0] readWord(input logic hit, input logic [1:0] idx,
                                           input dbtc_ctrl_t [1:0] ctrl, input logic [31:0] status);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (hit && isCtrl(idx)) begin
         w = {{(32 - `DBTC_CTRL_W){1'b0}}, ctrl[ctrlSlot(idx)]};
      end else if (hit && idx == IDX_STATUS) begin
         w = status;
      end
      return w;
   endfunction

   // gather the per-bus pins so both buses share one loop
   assign syncClk = {syncClockB, syncClockA};
   assign xData = {xmitDataB, xmitDataA};
   assign xDataInv = {xmitDataInvB, xmitDataInvA};
   assign rawPos = {busRcvPosB, busRcvPosA};
   assign rawNeg = {busRcvNegB, busRcvNegA};

   // one transmit lane per bus, each on its own sync clock
   for (genvar b = 0; b < 2; b++) begin : g_lane
      dbtc_xmit_lane u_lane (
         .clk(clk),
         .rst(rst),
         .syncClock(syncClk[b]),
         .xmitData(xData[b]),
         .xmitDataInv(xDataInv[b]),
         .xmitInhibit(st_reg.ctrl[b].xmitInhibit),
         .syncEnable(st_reg.ctrl[b].syncEnable),
         .trimCode(st_reg.ctrl[b].trimCode),
         .drvPos(drvPos[b]),
         .drvNeg(drvNeg[b]),
         .drvOe(drvOe[b]),
         .trimSel(trimSel[b])
      );
   end

   // status: one byte slice per bus showing receive and driver state
   always_comb begin
      statusWord = 32'h0000_0000;
      for (int b = 0; b < 2; b++) begin
         statusWord[b * `DBTC_ST_PITCH + `DBTC_ST_RCV] = st_reg.rcv[b][1].level;
         statusWord[b * `DBTC_ST_PITCH + `DBTC_ST_RCV_INV] = st_reg.rcv[b][0].level;
         statusWord[b * `DBTC_ST_PITCH + `DBTC_ST_DRV_POS] = drvPos[b];
         statusWord[b * `DBTC_ST_PITCH + `DBTC_ST_DRV_NEG] = drvNeg[b];
         statusWord[b * `DBTC_ST_PITCH + `DBTC_ST_DRV_OE] = drvOe[b];
      end
   end

   // address phase is taken only when the bus is ready and the transfer is real
   assign accept = hsel && htrans[1] && hready;

   // next state: receive stretching and the register slave
   always_comb begin
      st_next = st_reg;
      for (int b = 0; b < 2; b++) begin
         // comparator levels are asynchronous: two flops before use
         st_next.rcvSync[b][0] = {rawPos[b], rawNeg[b]};
         st_next.rcvSync[b][1] = st_reg.rcvSync[b][0];
         for (int p = 0; p < 2; p++) begin
            if (!st_reg.ctrl[b].rcvEnable) begin
               st_next.rcv[b][p] = '0;
            end else if (st_reg.rcv[b][p].count != '0) begin
               // inside a stretched pulse the output stays high whatever the bus does
               st_next.rcv[b][p].count = st_reg.rcv[b][p].count - 1'b1;
            end else if (st_reg.rcvSync[b][1][p] && !st_reg.rcv[b][p].level && st_reg.ctrl[b].stretchEn) begin
               st_next.rcv[b][p].level = 1'b1;
               st_next.rcv[b][p].count = STRETCH_LOAD;
            end else begin
               st_next.rcv[b][p].level = st_reg.rcvSync[b][1][p];
            end
         end
      end
      // data phase of a write lands in the addressed control register
      if (st_reg.dataPhase && st_reg.dataWrite && st_reg.dataHit && isCtrl(st_reg.dataIdx)) begin
         st_next.ctrl[ctrlSlot(st_reg.dataIdx)] = dbtc_ctrl_t'(hwdata[`DBTC_CTRL_W-1:0]);
      end
      st_next.dataPhase = accept;
      st_next.dataWrite = hwrite;
      st_next.dataHit = (haddr[31:4] == 28'h0000000) && (haddr[1:0] == 2'h0);
      st_next.dataIdx = haddr[3:2];
      // read data is fetched after any write finishing now, so write-then-read is coherent
      if (accept && !hwrite) begin
         st_next.rdata = readWord(st_next.dataHit, st_next.dataIdx, st_next.ctrl, statusWord);
      end
      if (rst) begin
         st_next = '0;
         st_next.ctrl[0] = dbtc_ctrl_t'(`DBTC_CTRL_RST);
         st_next.ctrl[1] = dbtc_ctrl_t'(`DBTC_CTRL_RST);
      end
   end

   always_ff @(posedge clk) begin
      st_reg <= st_next;
   end

   // the slave never inserts wait states and never errors
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = st_reg.rdata;

   // receive pairs: true output from the positive comparator, inverted from the negative
   assign rcvDataA = st_reg.rcv[0][1].level;
   assign rcvDataInvA = st_reg.rcv[0][0].level;
   assign rcvDataB = st_reg.rcv[1][1].level;
   assign rcvDataInvB = st_reg.rcv[1][0].level;

   // drivers and trim from the lanes
   assign lineDriverPosA = drvPos[0];
   assign lineDriverNegA = drvNeg[0];
   assign lineDriverOeA = drvOe[0];
   assign lineDriverPosB = drvPos[1];
   assign lineDriverNegB = drvNeg[1];
   assign lineDriverOeB = drvOe[1];
   assign trimSelA = trimSel[0];
   assign trimSelB = trimSel[1];

endmodule // dbtc_top

// File: dbtc_top_asserts.sv
module dbtc_top_asserts import dbtc_pkg::*; #(
   parameter int STRETCH_CYC = 15
) (
   // clock, reset, bus response
   input wire logic clk,
   input wire logic rst,
   input wire logic hreadyout,
   input wire logic hresp,
   // bus A; the run keeps it enabled, stretched, unsynced, uninhibited
   input wire logic xmitDataA,
   input wire logic xmitDataInvA,
   input wire logic busRcvPosA,
   input wire logic busRcvNegA,
   input wire logic rcvDataA,
   input wire logic rcvDataInvA,
   input wire logic lineDriverPosA,
   input wire logic lineDriverNegA,
   input wire logic lineDriverOeA,
   // bus B driver
   input wire logic lineDriverPosB,
   input wire logic lineDriverNegB,
   input wire logic lineDriverOeB
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // four settled pad samples, so the three-edge bypass path has caught up
   sequence padsLive;
      ($stable({xmitDataA, xmitDataInvA}) && xmitDataA != xmitDataInvA) [*4];
   endsequence
   sequence padsIdle;
      ($stable({xmitDataA, xmitDataInvA}) && xmitDataA == xmitDataInvA) [*4];
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("slave not ready or not okay");
   a_bypass_live: assert property (padsLive |-> lineDriverOeA &&
      {lineDriverPosA, lineDriverNegA} == {xmitDataA, xmitDataInvA})
      else $error("bus A driver not following pads");
   a_bypass_idle: assert property (padsIdle |-> !lineDriverOeA)
      else $error("bus A driving with equal pads");
   a_oe_pair: assert property (lineDriverOeB |-> lineDriverPosB != lineDriverNegB)
      else $error("bus B driving equal levels");
   a_follow_pos: assert property ($rose(busRcvPosA) |-> ##[2:3] rcvDataA)
      else $error("receive A missed a rise");
   a_follow_neg: assert property ($rose(busRcvNegA) |-> ##[2:3] rcvDataInvA)
      else $error("inverted receive A missed a rise");
   a_stretch_pos: assert property ($fell(rcvDataA) |-> $past(rcvDataA, STRETCH_CYC))
      else $error("receive A pulse too short");
   a_stretch_neg: assert property ($fell(rcvDataInvA) |-> $past(rcvDataInvA, STRETCH_CYC))
      else $error("inverted receive A pulse too short");
endmodule // dbtc_top_asserts

bind dbtc_top dbtc_top_asserts #(.STRETCH_CYC(STRETCH_CYC)) dbtc_top_asserts_inst (
   .clk(clk),
   .rst(rst),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .xmitDataA(xmitDataA),
   .xmitDataInvA(xmitDataInvA),
   .busRcvPosA(busRcvPosA),
   .busRcvNegA(busRcvNegA),
   .rcvDataA(rcvDataA),
   .rcvDataInvA(rcvDataInvA),
   .lineDriverPosA(lineDriverPosA),
   .lineDriverNegA(lineDriverNegA),
   .lineDriverOeA(lineDriverOeA),
   .lineDriverPosB(lineDriverPosB),
   .lineDriverNegB(lineDriverNegB),
   .lineDriverOeB(lineDriverOeB)
);

// File: dbtc_host_model.sv
module dbtc_host_model import dbtc_pkg::*; (
   // sync clock and transmit pair toward the device
   output logic syncClock,
   output logic xmitData,
   output logic xmitDataInv
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle bits at power-up so the capture flops leave their unknown state
   initial begin
      syncClock = 1'h1;
      xmitData = 1'h0;
      xmitDataInv = 1'h0;
      send(8'h0, 1'h1);
   end
   // launch on the falling edge; the last bit releases both lines to the pull-downs
   task automatic send(input logic [7:0] v, input logic idle);
      for (int i = 8; i >= 0; i--) begin
         #32 syncClock = 1'h0;
         xmitData = i > 0 && !idle && v[i - 1];
         xmitDataInv = i > 0 && !idle && !v[i - 1];
         #32 syncClock = 1'h1;
      end
   endtask
   // static levels with the clock parked high, off the system clock edge
   task automatic hold_pair(input logic a, b);
      #5 xmitData = a;
      xmitDataInv = b;
   endtask
endmodule // dbtc_host_model

// File: tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int STRETCH = 3;
   // bus master and bench-driven pins
   logic clk = 0, rst = 1, hsel = 0, hwrite = 0, noise = 0;
   logic [1:0] htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic syncClockA = 1, xmitDataA = 0, xmitDataInvA = 0;
   logic busRcvPosA = 0, busRcvNegA = 0, busRcvPosB = 0, busRcvNegB = 0;
   // design and host outputs
   logic hreadyout, hresp, syncClockB, xmitDataB, xmitDataInvB, rcvDataA, rcvDataInvA, rcvDataB, rcvDataInvB;
   logic lineDriverPosA, lineDriverNegA, lineDriverOeA, lineDriverPosB, lineDriverNegB, lineDriverOeB;
   logic [2:0] trimSelA, trimSelB;
   logic [8:0] runB = 0;
   logic lastB = 0;
   // one-cycle request to restart the bus B run log, so only the log process writes runB
   logic armB = 0;
   int seed = 32'hE966505F;
   int bad_count = 0;
   int tests_run = 0;
   int w, hiP, hiN;
   dbtc_top #(.STRETCH_CYC(STRETCH)) dbtc_top_inst (.hready(hreadyout), .hsize(3'h2), .*);
   dbtc_host_model dbtc_host_model_inst (.syncClock(syncClockB), .xmitData(xmitDataB), .xmitDataInv(xmitDataInvB));
   always #10 clk = ~clk;
   // random comparator activity on bus A feeds the checker
   always @(posedge clk) begin
      busRcvPosA <= noise && ($random(seed) & 32'h3) == 32'h0;
      busRcvNegA <= noise && ($random(seed) & 32'h3) == 32'h1;
   end
   // bus B driver levels while driving; repeats fold into one entry
   always @(posedge clk) begin
      if (armB) begin
         runB <= 9'h1;
      end else if (lineDriverOeB === 1'h1 && (runB == 9'h1 || lineDriverPosB !== lastB)) begin
         runB <= {runB[7:0], lineDriverPosB};
         lastB <= lineDriverPosB;
      end
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // hreadyout is always high today, but a stuck slave must not hang the run
   task automatic wait_ready;
      int n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'h1 && n < 64);
      if (n >= 64) begin
         chk(0, 1);
         report_and_stop;
      end
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, d);
      hsel <= 1'h1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      wait_ready;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready;
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [31:0] a, exp);
      ahb(1'h0, a, 0);
      chk(rd, exp);
   endtask
   // count high cycles of bus B receive outputs for pulses of the given widths
   task automatic pulse(input int wp, wn);
      hiP = 0;
      hiN = 0;
      for (int c = 0; c < 16; c++) begin
         busRcvPosB <= c < wp;
         busRcvNegB <= c < wn;
         @(posedge clk);
         hiP += rcvDataB !== 1'h0;
         hiN += rcvDataInvB !== 1'h0;
      end
   endtask
   function automatic int expect_hi(input int n, input logic en, st);
      return !en ? 0 : (st && n < STRETCH) ? STRETCH : n;
   endfunction
   function automatic logic [2:0] drv(input logic a, b);
      return {a ^ b, a & ~b, b & ~a};
   endfunction
   function automatic logic [8:0] squeeze(input logic [7:0] v);
      logic [8:0] r = 9'h1;
      for (int i = 7; i >= 0; i--)
         if (i == 7 || v[i] != v[i + 1]) r = {r[7:0], v[i]};
      return r;
   endfunction
   // main sequence
   initial begin
      repeat (14) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      rdchk(32'h0, 32'h5);
      rdchk(32'h4, 32'h5);
      rdchk(32'h8, 32'h0);
      chk({trimSelA, trimSelB}, 6'h0);
      ahb(1'h1, 32'hC, 32'h7F);
      rdchk(32'hC, 32'h0);
      w = $random(seed);
      ahb(1'h1, 32'h4, w);
      rdchk(32'h4, w & 32'h7F);
      for (int t = 0; t < 8; t++) begin
         ahb(1'h1, 32'h0, {t[2:0], 4'h5});
         ahb(1'h1, 32'h4, {~t[2:0], 4'h5});
         cyc(2);
         chk({trimSelA, trimSelB}, {t[2:0], ~t[2:0]});
      end
      $display("test registers done");
      noise <= 1'h1;
      for (int k = 0; k < 3; k++) begin
         ahb(1'h1, 32'h4, k == 0 ? 4 : 4 * k - 3);
         for (int j = 0; j < 4; j++) begin
            w = j == 0 ? 1 : 1 + ($random(seed) & 32'h3);
            pulse(w, w + 1);
            chk(hiP, expect_hi(w, k != 0, k == 2));
            chk(hiN, expect_hi(w + 1, k != 0, k == 2));
         end
      end
      $display("test receive done");
      noise <= 1'h0;
      for (int j = 0; j < 8; j++) begin
         w = $random(seed);
         xmitDataA <= w[0];
         xmitDataInvA <= w[1];
         cyc(6);
         chk({lineDriverOeA, lineDriverPosA & lineDriverOeA, lineDriverNegA & lineDriverOeA}, drv(w[0], w[1]));
      end
      xmitDataA <= 1'h1;
      xmitDataInvA <= 1'h0;
      cyc(6);
      ahb(1'h0, 32'h8, 0);
      chk(rd & 32'h1F, 32'h14);
      $display("test bus A transmit done");
      dbtc_host_model_inst.hold_pair(1'h1, 1'h0);
      @(posedge clk);
      ahb(1'h1, 32'h4, 32'h7);
      cyc(6);
      chk({lineDriverOeB, lineDriverOeA}, 2'h1);
      ahb(1'h1, 32'h4, 32'h5);
      cyc(6);
      chk({lineDriverOeB, lineDriverPosB, lineDriverNegB}, drv(1'h1, 1'h0));
      ahb(1'h1, 32'h4, 32'hD);
      cyc(6);
      chk(lineDriverOeB, 1'h0);
      dbtc_host_model_inst.hold_pair(1'h0, 1'h0);
      for (int j = 0; j < 3; j++) begin
         w = j == 0 ? 32'hA5 : $random(seed);
         @(posedge clk);
         armB <= 1'h1;
         @(posedge clk);
         armB <= 1'h0;
         #7;
         dbtc_host_model_inst.send(w[7:0], 1'h0);
         @(posedge clk);
         cyc(8);
         chk(runB, squeeze(w[7:0]));
         chk(lineDriverOeB, 1'h0);
      end
      $display("test bus B transmit done");
      report_and_stop;
   end
endmodule // tb_top
